// *** design/rng_lfsr.sv ***
/*
 * Galois shift register that stirs continuously while enabled.
 * Assumes the reset seed is non-zero.
 */
`timescale 1ns/1ns
module rng_lfsr #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] TAPS = '1,
    parameter logic [WIDTH-1:0] SEED = '1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Stir control and state
    input wire logic run,
    output logic [WIDTH-1:0] state
);
    logic [WIDTH-1:0] lfsr_reg;
    logic [WIDTH-1:0] lfsr_next;

    // Next state: shift with feedback on the taps
    always_comb begin
        lfsr_next = lfsr_reg;
        if (run) begin
            lfsr_next = {1'b0, lfsr_reg[WIDTH-1:1]} ^ (lfsr_reg[0] ? TAPS : '0);
        end
    end

    // Register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    assign state = lfsr_reg;
endmodule : rng_lfsr

// *** design/rng_pkg.sv ***
/*
 * Package of the random value generator: register map, field positions,
 * reset values, mode codes and timing constants.
 * Assumes a single clock domain running at the 25 MHz rate.
 */
package rng_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] RNG_CTRL_OFS = 4'h0;
    localparam logic [3:0] RNG_STAT_OFS = 4'h4;
    localparam logic [3:0] RNG_VALUE_OFS = 4'h8;
    localparam logic [3:0] RNG_IRQ_STAT_OFS = 4'hC;

    // ----------------------------------------
    // Control fields: start, stop, mode, interrupt enable
    // ----------------------------------------
    localparam int RNG_CTRL_START_BIT = 0;
    localparam int RNG_CTRL_STOP_BIT = 1;
    localparam int RNG_CTRL_MODE_BIT = 2;
    localparam int RNG_CTRL_IRQEN_BIT = 3;

    // Status fields
    localparam int RNG_STAT_AVAIL_BIT = 0;
    localparam int RNG_STAT_RUN_BIT = 1;
    localparam int RNG_STAT_MODE_BIT = 2;
    localparam int RNG_STAT_IRQEN_BIT = 3;

    // Interrupt status field, write one to clear
    localparam int RNG_IRQ_STAT_BIT = 0;

    // Mode and interrupt codes
    localparam logic one_value_mode_code = 1'b0;
    localparam logic free_running_mode_code = 1'b1;
    localparam logic irq_off_code = 1'b0;
    localparam logic irq_on_code = 1'b1;

    // ----------------------------------------
    // Widths, reset values, timing
    // ----------------------------------------
    localparam int RNG_VALUE_W = 16;
    localparam int RNG_ADDR_W = 4;
    localparam int RNG_DATA_W = 32;
    localparam logic [15:0] RNG_LFSR_SEED = 16'hACE1;
    localparam logic [15:0] RNG_LFSR_TAPS = 16'hB400;
    localparam logic [15:0] RNG_VALUE_RST = 16'h0000;
    localparam int RNG_CLK_HZ = 25_000_000;
    localparam int RNG_PERIOD_US = 256;
    localparam int RNG_PERIOD_CYC = (RNG_CLK_HZ / 1_000_000) * RNG_PERIOD_US;
    localparam int RNG_CNT_W = 16;

    // Generator states
    typedef enum logic [2:0] {
        RNG_IDLE = 3'b001,
        RNG_RUN = 3'b010,
        RNG_DONE = 3'b100
    } rng_state_t;

endpackage : rng_pkg

// *** design/rng_top.sv ***
/*
 * Random value generator with register port and interrupt logic.
 * Software starts it with mode and interrupt enable, stops it, polls
 * availability and reads the 16-bit value.
 * Assumes a synchronous single-cycle register master on the clock.
 */
`timescale 1ns/1ns
module rng_top
    import rng_pkg::*;
#(
    parameter int PERIOD_CYC = rng_pkg::RNG_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [rng_pkg::RNG_ADDR_W-1:0] reg_addr,
    input wire logic [rng_pkg::RNG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [rng_pkg::RNG_DATA_W-1:0] reg_rdata,
    // Interrupt towards the system controller
    output logic sysctrl_irq
);
    import rng_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    rng_state_t state_reg;
    rng_state_t state_next;
    logic mode_reg;
    logic mode_next;
    logic irqen_reg;
    logic irqen_next;
    logic [RNG_CNT_W-1:0] cnt_reg;
    logic [RNG_CNT_W-1:0] cnt_next;
    logic [RNG_VALUE_W-1:0] value_reg;
    logic [RNG_VALUE_W-1:0] value_next;
    logic avail_reg;
    logic avail_next;
    logic irq_stat_reg;
    logic irq_stat_next;
    logic irq_mask_reg;
    logic irq_mask_next;
    logic [RNG_DATA_W-1:0] rdata_reg;
    logic [RNG_DATA_W-1:0] rdata_next;
    logic [RNG_VALUE_W-1:0] lfsr_state;
    logic start_cmd;
    logic stop_cmd;
    logic value_rd;
    logic produce;
    logic running;

    // ----------------------------------------
    // Decode
    // ----------------------------------------

    // Command strobes from control writes
    assign start_cmd = reg_write && (reg_addr == RNG_CTRL_OFS) && reg_wdata[RNG_CTRL_START_BIT];
    assign stop_cmd = reg_write && (reg_addr == RNG_CTRL_OFS) && reg_wdata[RNG_CTRL_STOP_BIT];
    assign value_rd = reg_read && (reg_addr == RNG_VALUE_OFS);
    assign running = (state_reg == RNG_RUN);
    // A value completes at the end of each period
    assign produce = running && (cnt_reg == RNG_CNT_W'(PERIOD_CYC - 1));

    // Entropy source, stirred every cycle
    rng_lfsr #(
        .WIDTH(RNG_VALUE_W),
        .TAPS(RNG_LFSR_TAPS),
        .SEED(RNG_LFSR_SEED)
    ) u_lfsr (
        .clock(clock),
        .rst_n(rst_n),
        .run(1'b1),
        .state(lfsr_state)
    );

    // ----------------------------------------
    // Generator sequencing
    // ----------------------------------------

    // State, mode and period counter
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        irqen_next = irqen_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            RNG_IDLE, RNG_DONE: begin
                cnt_next = '0;
            end
            RNG_RUN: begin
                if (produce) begin
                    cnt_next = '0;
                    if (mode_reg == one_value_mode_code) begin
                        state_next = RNG_DONE;
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = RNG_IDLE;
                cnt_next = '0;
            end
        endcase
        if (stop_cmd && !start_cmd) begin
            state_next = RNG_IDLE;
            cnt_next = '0;
        end
        if (start_cmd) begin
            state_next = RNG_RUN;
            cnt_next = '0;
            mode_next = reg_wdata[RNG_CTRL_MODE_BIT];
            irqen_next = reg_wdata[RNG_CTRL_IRQEN_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= RNG_IDLE;
            mode_reg <= one_value_mode_code;
            irqen_reg <= irq_off_code;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            irqen_reg <= irqen_next;
            cnt_reg <= cnt_next;
        end
    end

    // ----------------------------------------
    // Value, availability and interrupt
    // ----------------------------------------

    // Capture value; set wins over the clear by read
    always_comb begin
        value_next = value_reg;
        avail_next = avail_reg;
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (value_rd) begin
            avail_next = 1'b0;
            irq_stat_next = 1'b0;
        end
        if (reg_write && (reg_addr == RNG_IRQ_STAT_OFS) && reg_wdata[RNG_IRQ_STAT_BIT]) begin
            irq_stat_next = 1'b0;
        end
        if (start_cmd) begin
            irq_mask_next = reg_wdata[RNG_CTRL_IRQEN_BIT];
        end
        if (produce) begin
            value_next = lfsr_state;
            avail_next = 1'b1;
            irq_stat_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RNG_VALUE_RST;
            avail_reg <= 1'b0;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            avail_reg <= avail_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Level interrupt to system controller
    assign sysctrl_irq = irq_stat_reg & irq_mask_reg & irqen_reg;

    // ----------------------------------------
    // Read data
    // ----------------------------------------

    // Read mux; data stand one cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (reg_read) begin
            case (reg_addr)
                RNG_STAT_OFS: begin
                    rdata_next[RNG_STAT_AVAIL_BIT] = avail_reg;
                    rdata_next[RNG_STAT_RUN_BIT] = running;
                    rdata_next[RNG_STAT_MODE_BIT] = mode_reg;
                    rdata_next[RNG_STAT_IRQEN_BIT] = irqen_reg;
                end
                RNG_VALUE_OFS: begin
                    rdata_next[RNG_VALUE_W-1:0] = value_reg;
                end
                RNG_IRQ_STAT_OFS: begin
                    rdata_next[RNG_IRQ_STAT_BIT] = irq_stat_reg;
                end
                RNG_CTRL_OFS: begin
                    rdata_next[RNG_CTRL_MODE_BIT] = mode_reg;
                    rdata_next[RNG_CTRL_IRQEN_BIT] = irqen_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule : rng_top

// *** verification/rng_top_props.sv ***
/* Port checker of the random value generator.
   Bound to rng_top from the bench top file. */
`timescale 1ns/1ns
module rng_top_props
    import rng_pkg::*;
#(
    parameter int PERIOD_CYC = rng_pkg::RNG_PERIOD_CYC
) (
    // Clock, reset and register port
    input logic clock,
    input logic rst_n,
    input logic [rng_pkg::RNG_ADDR_W-1:0] reg_addr,
    input logic [rng_pkg::RNG_DATA_W-1:0] reg_wdata,
    input logic reg_write,
    input logic reg_read,
    input logic [rng_pkg::RNG_DATA_W-1:0] reg_rdata,
    input logic sysctrl_irq
);
    // ----------------
    // Helper state
    // ----------------
    logic st;
    logic en_reg;
    logic mode_reg;
    logic rd_reg;
    logic [3:0] ra_reg;
    logic [15:0] age_reg;
    logic [1:0] rises_reg;
    assign st = reg_write && reg_addr == RNG_CTRL_OFS && reg_wdata[RNG_CTRL_START_BIT];

    // Settings from start, age and rises since start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= 1'b0;
            mode_reg <= 1'b0;
            rd_reg <= 1'b0;
            ra_reg <= 4'h0;
            age_reg <= 16'h0000;
            rises_reg <= 2'h0;
        end else begin
            rd_reg <= reg_read;
            ra_reg <= reg_addr;
            if (st) begin
                en_reg <= reg_wdata[RNG_CTRL_IRQEN_BIT];
                mode_reg <= reg_wdata[RNG_CTRL_MODE_BIT];
                age_reg <= 16'h0000;
                rises_reg <= 2'h0;
            end else begin
                age_reg <= (age_reg == 16'hFFFF) ? age_reg : age_reg + 16'h0001;
                rises_reg <= ($rose(sysctrl_irq) && rises_reg != 2'h3) ? rises_reg + 2'h1
                    : rises_reg;
            end
        end
    end

    // ----------------
    // Assertions
    // ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!rd_reg |-> reg_rdata == '0)
        else $error("read data without a read");
    a_value_width: assert property (rd_reg && ra_reg == RNG_VALUE_OFS
        |-> reg_rdata[31:16] == '0)
        else $error("value word wider than 16 bits");
    a_stat_no_value: assert property (rd_reg && ra_reg == RNG_STAT_OFS
        |-> reg_rdata[31:4] == '0)
        else $error("status word carries value bits");
    a_irq_mask: assert property (!en_reg |-> !sysctrl_irq)
        else $error("interrupt while disabled at start");
    a_first_wait: assert property ($rose(sysctrl_irq) && age_reg != '0
        |-> age_reg >= PERIOD_CYC - 2)
        else $error("value came before one period");
    a_single_once: assert property ($rose(sysctrl_irq) && mode_reg == one_value_mode_code
        |-> rises_reg == 2'h0)
        else $error("second value in single-shot");
    a_irq_holds: assert property (sysctrl_irq && !reg_write
        && !(reg_read && reg_addr == RNG_VALUE_OFS) |=> sysctrl_irq)
        else $error("interrupt dropped on its own");
    a_read_clears: assert property (sysctrl_irq && reg_read
        && reg_addr == RNG_VALUE_OFS |-> ##[1:2] !sysctrl_irq)
        else $error("value read left interrupt set");

    // Main scenarios reached
    c_cont: cover property ($rose(sysctrl_irq) && mode_reg == free_running_mode_code);
    c_value: cover property (rd_reg && ra_reg == RNG_VALUE_OFS && reg_rdata != '0);
    c_start: cover property (st && reg_wdata[RNG_CTRL_MODE_BIT]);
endmodule : rng_top_props

// *** verification/rng_top_tb.sv ***
/* Bench of the random value generator: reset table, single-shot,
   continuous, stop, clear and reset cases. Assumes a short period. */
`timescale 1ns/1ns
module rng_top_tb;
    import rng_pkg::*;
    localparam int PER = 8;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic sysctrl_irq;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    logic [31:0] d;
    logic [31:0] v;
    typedef struct {logic [3:0] a; logic [31:0] e;} rng_row_t;
    rng_row_t rows [6] = '{'{RNG_CTRL_OFS, 32'h0000_0000}, '{RNG_STAT_OFS, 32'h0000_0000},
        '{RNG_VALUE_OFS, 32'h0000_0000}, '{RNG_IRQ_STAT_OFS, 32'h0000_0000},
        '{4'h2, 32'h0000_0000}, '{4'hF, 32'h0000_0000}};

    // Clock and cycle count
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    rng_top #(.PERIOD_CYC(PER)) uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sysctrl_irq(sysctrl_irq));

    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask : rd
    task automatic wirq;
        for (int i = 0; i < 40 && sysctrl_irq !== 1'b1; i++) @(negedge clock);
        chk("irq", 32'h0000_0001, 32'(sysctrl_irq));
    endtask : wirq
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a);
            chk("reset", rows[i].e, d);
        end
        // Single-shot, interrupt off, polled
        wr(RNG_CTRL_OFS, 32'h0000_0001);
        rd(RNG_STAT_OFS);
        chk("run", 32'h0000_0002, d);
        for (int i = 0; i < 20 && d[0] !== 1'b1; i++) rd(RNG_STAT_OFS);
        chk("avail", 32'h0000_0001, d);
        chk("noirq", 32'h0000_0000, 32'(sysctrl_irq));
        rd(RNG_VALUE_OFS);
        v = d;
        chk("width", 32'h0000_0000, 32'(v[31:16]));
        rd(RNG_STAT_OFS);
        chk("clear", 32'h0000_0000, d);
        repeat (3 * PER) @(posedge clock);
        rd(RNG_STAT_OFS);
        chk("halt", 32'h0000_0000, d);
        rd(RNG_VALUE_OFS);
        chk("last", v, d);
        // Single-shot, interrupt on
        wr(RNG_CTRL_OFS, 32'h0000_0009);
        wirq();
        rd(RNG_STAT_OFS);
        chk("stat", 32'h0000_0009, d);
        rd(RNG_VALUE_OFS);
        chk("new", 32'h0000_0001, 32'(d != v));
        v = d;
        chk("irqclr", 32'h0000_0000, 32'(sysctrl_irq));
        // Continuous: spacing and fresh values
        wr(RNG_CTRL_OFS, 32'h0000_000D);
        rd(RNG_STAT_OFS);
        chk("mode", 32'h0000_000E, d);
        rd(RNG_CTRL_OFS);
        chk("ctrl", 32'h0000_000C, d);
        wirq();
        for (int k = 0; k < 3; k++) begin
            t0 = cyc;
            rd(RNG_VALUE_OFS);
            chk("fresh", 32'h0000_0001, 32'(d != v));
            v = d;
            wirq();
            chk("gap", 32'(PER), 32'(cyc - t0));
        end
        // Stop, then clear the pending interrupt
        rd(RNG_IRQ_STAT_OFS);
        chk("pend", 32'h0000_0001, d);
        wr(RNG_CTRL_OFS, 32'h0000_0002);
        wr(RNG_IRQ_STAT_OFS, 32'h0000_0001);
        @(negedge clock);
        chk("w1c", 32'h0000_0000, 32'(sysctrl_irq));
        repeat (3 * PER) @(negedge clock);
        chk("stop", 32'h0000_0000, 32'(sysctrl_irq));
        rd(RNG_STAT_OFS);
        chk("idle", 32'h0000_000D, d);
        // Reset in mid-run with an interrupt pending
        wr(RNG_CTRL_OFS, 32'h0000_000D);
        wirq();
        @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        chk("rstirq", 32'h0000_0000, 32'(sysctrl_irq));
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (2 * PER) @(posedge clock);
        rd(RNG_STAT_OFS);
        chk("rst", 32'h0000_0000, d);
        // Start and stop in one write: start wins
        wr(RNG_CTRL_OFS, 32'h0000_0003);
        rd(RNG_STAT_OFS);
        chk("both", 32'h0000_0002, d);
        final_report();
    end

    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge clock);
        mismatches++;
        final_report();
    end
endmodule : rng_top_tb

bind rng_top rng_top_props #(.PERIOD_CYC(PERIOD_CYC)) u_props (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sysctrl_irq(sysctrl_irq));
